// *** rtl/ricbh_pkg.sv ***
// shared constants and types for the resolver command byte handler
package ricbh_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned TSTAMP_NS       = 400;
    localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
    localparam int unsigned TSTAMP_CYC      = (TSTAMP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FLASH_LIFE      = 10_000;
    localparam logic [7:0] CMD_VELOCITY     = 8'h00;
    localparam logic [7:0] CMD_PRESET_ARM   = 8'h02;
    localparam logic [7:0] CMD_PRESET_EXEC  = 8'h0d;
    localparam logic [7:0] CMD_UNITS_SPAN   = 8'h10;
    localparam logic [7:0] CMD_TOTAL_RANGE  = 8'h11;
    localparam logic [7:0] CMD_PRESET_VAL   = 8'h13;
    localparam logic [7:0] CMD_SAVE_ARM     = 8'h20;
    localparam logic [7:0] CMD_OFFSET       = 8'h33;
    localparam logic [7:0] CMD_TIMESTAMP    = 8'h68;
    localparam logic [7:0] CMD_RAW_POS      = 8'h69;
    localparam logic [7:0] CMD_SAVE_EXEC    = 8'hd0;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        SEQ_IDLE    = 3'b001,
        SEQ_PRE_ARM = 3'b010,
        SEQ_SAV_ARM = 3'b100
    } ricbh_seq_type;

    typedef enum logic [2:0]
    {
        NV_IDLE  = 3'b001,
        NV_WRITE = 3'b010,
        NV_WAIT  = 3'b100
    } ricbh_nv_type;
endpackage

// *** rtl/ricbh_nv_if.sv ***
// save request and completion between sequencer and nonvolatile writer
`timescale 1ns/100ps
interface ricbh_nv_if;
    logic        save_req;
    logic [31:0] offset;
    logic        busy;
    modport seq (output save_req, output offset, input busy);
    modport nv  (input save_req, input offset, output busy);
endinterface

// *** rtl/ricbh_tstamp.sv ***
// free-running time stamp, one count per 400 ns
`timescale 1ns/100ps
module ricbh_tstamp
    import ricbh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    output logic      [31:0] stamp_o
);
    logic [7:0] div_q;
    logic       tick;

    assign tick = (div_q == 8'(TSTAMP_CYC - 1));

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            div_q <= 8'h00;
        else if (tick)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            stamp_o <= ZERO_WORD;
        else if (tick)
            stamp_o <= stamp_o + 32'h0000_0001;
    end

    property p_stamp_step;
        @(posedge clk_i) disable iff (!arst_n_i)
        tick |=> stamp_o == $past(stamp_o) + 32'h0000_0001;
    endproperty
    a_stamp_step : assert property (p_stamp_step)
        else $error("time stamp did not advance on tick");

    property p_stamp_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !tick |=> $stable(stamp_o);
    endproperty
    a_stamp_hold : assert property (p_stamp_hold)
        else $error("time stamp moved between ticks");
endmodule

// *** rtl/ricbh_nvstore.sv ***
// nonvolatile writer: flash or ferroelectric store with write counting
`timescale 1ns/100ps
module ricbh_nvstore
    import ricbh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    ricbh_nv_if.nv           nv,
    input  wire logic        fram_sel_i,
    input  wire logic        nv_ack_i,
    output logic             flash_wr_o,
    output logic             fram_wr_o,
    output logic             wear_err_o
);
    ricbh_nv_type state_q;
    logic [13:0]  wcount_q;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_q <= NV_IDLE;
        else
            unique case (state_q)
                NV_IDLE:  if (nv.save_req) state_q <= NV_WRITE;
                NV_WRITE: state_q <= NV_WAIT;
                NV_WAIT:  if (nv_ack_i) state_q <= NV_IDLE;
                default:  state_q <= NV_IDLE;
            endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flash_wr_o <= 1'b0;
            fram_wr_o  <= 1'b0;
        end
        else
        begin
            flash_wr_o <= (state_q == NV_WRITE) && !fram_sel_i;
            fram_wr_o  <= (state_q == NV_WRITE) && fram_sel_i;
        end
    end

    // count flash writes, flag wear-out past rated life
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wcount_q   <= 14'h0000;
            wear_err_o <= 1'b0;
        end
        else if (state_q == NV_WRITE && !fram_sel_i)
        begin
            if (wcount_q != 14'h3fff)
                wcount_q <= wcount_q + 14'h0001;
            wear_err_o <= (wcount_q >= 14'(FLASH_LIFE));
        end
    end

    assign nv.busy = (state_q != NV_IDLE);

    property p_fram_sel;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_q == NV_WRITE && fram_sel_i) |=> fram_wr_o && !flash_wr_o;
    endproperty
    a_fram_sel : assert property (p_fram_sel)
        else $error("range nonzero but flash written");

    property p_flash_sel;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_q == NV_WRITE && !fram_sel_i) |=> flash_wr_o && !fram_wr_o;
    endproperty
    a_flash_sel : assert property (p_flash_sel)
        else $error("flash save not issued");
endmodule

// *** rtl/ricbh_top.sv ***
// resolver cyclic I/O command byte interpreter
`timescale 1ns/100ps
// Behaviour
// - cmd 10/11/13 put units-per-span, total range, preset value in word 2.
// - cmd 33 puts the offset from the last preset in word 2.
// - cmd 68 puts a free-running 400 ns time stamp in word 2.
// - cmd 69 puts raw position in word 2; word 1 stays scaled.
// - cmd 00 or unknown code gives velocity, no error.
// - preset execute after arm makes reported position equal preset.
// - offset and parameters are volatile until saved.
// - save execute after arm writes offset to flash when total range is zero.
// - flash rated for 10000 writes; beyond that flag memory error.
// - nonzero total range keeps offset in ferroelectric memory.
// - eight input bytes: scaled position, then selected value.
// - five output bytes: signed preset value then command byte.
module ricbh_top
    import ricbh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        out_valid_i,
    input  wire logic [39:0] out_bytes_i,
    input  wire logic [31:0] scaled_pos_i,
    input  wire logic [31:0] raw_pos_i,
    input  wire logic [31:0] velocity_i,
    input  wire logic [31:0] units_span_i,
    input  wire logic [31:0] total_range_i,
    input  wire logic        nv_ack_i,
    output logic      [63:0] in_bytes_o,
    output logic             in_valid_o,
    output logic      [31:0] offset_o,
    output logic      [31:0] preset_val_o,
    output logic             flash_wr_o,
    output logic             fram_wr_o,
    output logic      [31:0] nv_offset_o,
    output logic             wear_err_o
);
    ricbh_nv_if    nvb ();
    ricbh_seq_type seq_q;
    logic [7:0]    cmd;
    logic [31:0]   preset_in;
    logic [31:0]   stamp;
    logic [31:0]   sel_word;
    logic [31:0]   pos_now;
    logic          do_preset;
    logic          do_save;
    logic          save_req_q;

    assign preset_in = out_bytes_i[31:0];
    assign cmd       = out_bytes_i[39:32];

    // reported position is scaled position plus preset offset
    function automatic logic [31:0] pos_with_offset(input logic [31:0] p,
                                                    input logic [31:0] o);
        pos_with_offset = p + o;
    endfunction

    assign pos_now = pos_with_offset(scaled_pos_i, offset_o);

    // execute counts only right after its arming code
    assign do_preset = out_valid_i && (seq_q == SEQ_PRE_ARM) && (cmd == CMD_PRESET_EXEC);
    assign do_save   = out_valid_i && (seq_q == SEQ_SAV_ARM) && (cmd == CMD_SAVE_EXEC);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            seq_q <= SEQ_IDLE;
        else if (out_valid_i)
            unique case (cmd)
                CMD_PRESET_ARM: seq_q <= SEQ_PRE_ARM;
                CMD_SAVE_ARM:   seq_q <= SEQ_SAV_ARM;
                default:        seq_q <= SEQ_IDLE;
            endcase
    end

    // offset and preset held in plain flip-flops, lost at power loss
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            offset_o     <= ZERO_WORD;
            preset_val_o <= ZERO_WORD;
        end
        else if (do_preset)
        begin
            offset_o     <= preset_in - scaled_pos_i;
            preset_val_o <= preset_in;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            save_req_q <= 1'b0;
        else
            save_req_q <= do_save && !nvb.busy;
    end

    assign nvb.save_req = save_req_q;
    assign nvb.offset   = offset_o;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            nv_offset_o <= ZERO_WORD;
        else if (save_req_q)
            nv_offset_o <= nvb.offset;
    end

    always_comb
    begin
        unique case (cmd)
            CMD_UNITS_SPAN:  sel_word = units_span_i;
            CMD_TOTAL_RANGE: sel_word = total_range_i;
            CMD_PRESET_VAL:  sel_word = preset_val_o;
            CMD_OFFSET:      sel_word = offset_o;
            CMD_TIMESTAMP:   sel_word = stamp;
            CMD_RAW_POS:     sel_word = raw_pos_i;
            default:         sel_word = velocity_i;
        endcase
    end

    // fresh answer built on every transfer
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            in_bytes_o <= {ZERO_WORD, ZERO_WORD};
            in_valid_o <= 1'b0;
        end
        else
        begin
            in_valid_o <= out_valid_i;
            if (out_valid_i)
            begin
                if (do_preset)
                    in_bytes_o <= {velocity_i, preset_in};
                else
                    in_bytes_o <= {sel_word, pos_now};
            end
        end
    end

    ricbh_tstamp u_tstamp
    (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .stamp_o  (stamp)
    );

    ricbh_nvstore u_nv
    (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .nv         (nvb),
        .fram_sel_i (total_range_i != ZERO_WORD),
        .nv_ack_i   (nv_ack_i),
        .flash_wr_o (flash_wr_o),
        .fram_wr_o  (fram_wr_o),
        .wear_err_o (wear_err_o)
    );

    property p_sel_units;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_UNITS_SPAN) |=> in_bytes_o[63:32] == $past(units_span_i);
    endproperty
    a_sel_units : assert property (p_sel_units)
        else $error("units per span not selected");

    property p_sel_range;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_TOTAL_RANGE) |=> in_bytes_o[63:32] == $past(total_range_i);
    endproperty
    a_sel_range : assert property (p_sel_range)
        else $error("total range not selected");

    property p_sel_preset;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_PRESET_VAL) |=> in_bytes_o[63:32] == $past(preset_val_o);
    endproperty
    a_sel_preset : assert property (p_sel_preset)
        else $error("preset value not selected");

    property p_offset_rep;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_OFFSET) |=> in_bytes_o[63:32] == $past(offset_o);
    endproperty
    a_offset_rep : assert property (p_offset_rep)
        else $error("offset not reported");

    property p_sel_stamp;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_TIMESTAMP) |=> in_bytes_o[63:32] == $past(stamp);
    endproperty
    a_sel_stamp : assert property (p_sel_stamp)
        else $error("time stamp not selected");

    property p_raw_pos;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_RAW_POS && !do_preset)
        |=> in_bytes_o[63:32] == $past(raw_pos_i)
            && in_bytes_o[31:0] == $past(pos_now);
    endproperty
    a_raw_pos : assert property (p_raw_pos)
        else $error("raw position word wrong");

    property p_sel_vel;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_VELOCITY) |=> in_bytes_o[63:32] == $past(velocity_i);
    endproperty
    a_sel_vel : assert property (p_sel_vel)
        else $error("velocity not selected");

    property p_unknown_vel;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == 8'h55) |=> in_bytes_o[63:32] == $past(velocity_i);
    endproperty
    a_unknown_vel : assert property (p_unknown_vel)
        else $error("unknown code did not return velocity");

    property p_preset_pos;
        @(posedge clk_i) disable iff (!arst_n_i)
        do_preset |=> in_bytes_o[31:0] == $past(preset_in)
                      && offset_o == $past(preset_in) - $past(scaled_pos_i);
    endproperty
    a_preset_pos : assert property (p_preset_pos)
        else $error("preset did not set position");

    property p_preset_val;
        @(posedge clk_i) disable iff (!arst_n_i)
        do_preset |=> preset_val_o == $past(preset_in);
    endproperty
    a_preset_val : assert property (p_preset_val)
        else $error("preset value not stored");

    property p_offset_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !do_preset |=> $stable(offset_o);
    endproperty
    a_offset_hold : assert property (p_offset_hold)
        else $error("offset moved without preset");

    property p_save_req;
        @(posedge clk_i) disable iff (!arst_n_i)
        (do_save && !nvb.busy) |=> save_req_q ##2 (flash_wr_o || fram_wr_o);
    endproperty
    a_save_req : assert property (p_save_req)
        else $error("save did not reach nonvolatile store");

    property p_answer;
        @(posedge clk_i) disable iff (!arst_n_i)
        out_valid_i |=> in_valid_o;
    endproperty
    a_answer : assert property (p_answer)
        else $error("transfer not answered");

    property p_answer_idle;
        @(posedge clk_i) disable iff (!arst_n_i)
        !out_valid_i |=> !in_valid_o && $stable(in_bytes_o);
    endproperty
    a_answer_idle : assert property (p_answer_idle)
        else $error("answer changed without transfer");

    property p_pos_word;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && !do_preset) |=> in_bytes_o[31:0] == $past(scaled_pos_i) + $past(offset_o);
    endproperty
    a_pos_word : assert property (p_pos_word)
        else $error("position word not refreshed");

    property p_once;
        @(posedge clk_i) disable iff (!arst_n_i)
        do_preset |=> !do_preset;
    endproperty
    a_once : assert property (p_once)
        else $error("preset executed twice in a row");

    property p_no_stray;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_PRESET_EXEC && seq_q != SEQ_PRE_ARM) |=> $stable(offset_o);
    endproperty
    a_no_stray : assert property (p_no_stray)
        else $error("preset without arming");

    property p_save_stray;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_SAVE_EXEC && seq_q != SEQ_SAV_ARM) |=> !save_req_q;
    endproperty
    a_save_stray : assert property (p_save_stray)
        else $error("save without arming");

    property p_pre_arm;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_PRESET_ARM) |=> seq_q == SEQ_PRE_ARM;
    endproperty
    a_pre_arm : assert property (p_pre_arm)
        else $error("preset not armed");

    property p_sav_arm;
        @(posedge clk_i) disable iff (!arst_n_i)
        (out_valid_i && cmd == CMD_SAVE_ARM) |=> seq_q == SEQ_SAV_ARM;
    endproperty
    a_sav_arm : assert property (p_sav_arm)
        else $error("save not armed");
endmodule

// *** sim/ricbh_scanner.sv ***
// scanner model: sends output transfers and collects the input reply
`timescale 1ns/100ps
module ricbh_scanner
    import ricbh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        in_valid_i,
    input  wire logic [63:0] in_bytes_i,
    output logic             out_valid_o,
    output logic      [39:0] out_bytes_o
);
    logic [63:0] rx;
    logic        late;

    initial
    begin
        out_valid_o = 1'b0;
        out_bytes_o = 40'h00_0000_0000;
        rx          = 64'h0;
        late        = 1'b0;
    end

    // one transfer; bytes inverted once delivered so stale data never looks valid
    task automatic send(input logic [7:0] cmd, input logic [31:0] pre);
        int n;
        begin
            @(negedge clk_i);
            out_valid_o = 1'b1;
            out_bytes_o = {cmd, pre};
            @(negedge clk_i);
            out_valid_o = 1'b0;
            out_bytes_o = ~out_bytes_o;
            n = 0;
            while (in_valid_i !== 1'b1 && n < 8)
            begin
                @(negedge clk_i);
                n++;
            end
            late = late || (in_valid_i !== 1'b1) || (n != 0);
            rx   = in_bytes_i;
        end
    endtask

    // arm held for one delivered transfer, then execute
    task automatic preset(input logic [31:0] pre);
        begin
            send(CMD_PRESET_ARM, pre);
            send(CMD_PRESET_EXEC, pre);
        end
    endtask

    task automatic save();
        begin
            send(CMD_SAVE_ARM, 32'h0);
            send(CMD_SAVE_EXEC, 32'h0);
        end
    endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the command byte handler
`timescale 1ns/100ps
module tb;
    import ricbh_pkg::*;
    logic        clk_i = 1'b0;
    logic        arst_n_i, nv_ack_i, out_valid_i, in_valid_o, flash_wr_o, fram_wr_o, wear_err_o;
    logic [39:0] out_bytes_i;
    logic [31:0] scaled_pos_i, raw_pos_i, velocity_i, units_span_i, total_range_i;
    logic [31:0] offset_o, preset_val_o, nv_offset_o, exp_off;
    logic [63:0] in_bytes_o;
    int          n_fail = 0, n_tests = 0, n_flash = 0, n_fram = 0;

    always #10 clk_i = ~clk_i;

    ricbh_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .out_valid_i(out_valid_i),
        .out_bytes_i(out_bytes_i), .scaled_pos_i(scaled_pos_i), .raw_pos_i(raw_pos_i),
        .velocity_i(velocity_i), .units_span_i(units_span_i), .total_range_i(total_range_i),
        .nv_ack_i(nv_ack_i), .in_bytes_o(in_bytes_o), .in_valid_o(in_valid_o),
        .offset_o(offset_o), .preset_val_o(preset_val_o), .flash_wr_o(flash_wr_o),
        .fram_wr_o(fram_wr_o), .nv_offset_o(nv_offset_o), .wear_err_o(wear_err_o));

    ricbh_scanner i_scan (.clk_i(clk_i), .in_valid_i(in_valid_o), .in_bytes_i(in_bytes_o),
        .out_valid_o(out_valid_i), .out_bytes_o(out_bytes_i));

    always @(posedge clk_i)
    begin
        if (flash_wr_o === 1'b1) n_flash++;
        if (fram_wr_o === 1'b1) n_fram++;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        begin
            n_tests++;
            if (got !== exp)
            begin
                n_fail++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // reply missing or late ends the run
    task automatic chk_late();
        begin
            chk(i_scan.late, 1'b0);
            if (i_scan.late)
                end_of_test();
        end
    endtask

    task automatic sel(input logic [7:0] cmd, input logic [31:0] exp);
        begin
            xfer(cmd);
            chk(i_scan.rx[63:32], exp);
        end
    endtask

    // plain transfer; word 1 must be scaled position plus current offset
    task automatic xfer(input logic [7:0] cmd);
        begin
            i_scan.send(cmd, 32'h0);
            chk_late();
            chk(i_scan.rx[31:0], scaled_pos_i + exp_off);
        end
    endtask

    task automatic end_of_test();
        begin
            $display("checks %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    task automatic t_select();
        begin
            sel(CMD_VELOCITY, velocity_i);
            sel(CMD_UNITS_SPAN, units_span_i);
            units_span_i = 32'h0000_2345;
            sel(CMD_UNITS_SPAN, 32'h0000_2345);
            sel(CMD_TOTAL_RANGE, total_range_i);
            sel(CMD_RAW_POS, raw_pos_i);
            sel(8'h55, velocity_i);
            sel(CMD_PRESET_EXEC, velocity_i);
        end
    endtask

    task automatic t_preset();
        begin
            exp_off = 32'hffff_ff00 - scaled_pos_i;
            i_scan.preset(32'hffff_ff00);
            chk_late();
            chk(i_scan.rx, {velocity_i, 32'hffff_ff00});
            chk(offset_o, exp_off);
            chk(preset_val_o, 32'hffff_ff00);
            i_scan.send(CMD_PRESET_EXEC, 32'h0000_0042);
            chk_late();
            chk(offset_o, exp_off);
            xfer(CMD_OFFSET);
            chk(i_scan.rx[63:32], exp_off);
            xfer(CMD_PRESET_VAL);
            chk(i_scan.rx[63:32], 32'hffff_ff00);
            scaled_pos_i = 32'h0000_0777;
            i_scan.send(CMD_PRESET_EXEC, 32'h0000_0042);
            chk_late();
            chk(i_scan.rx, {velocity_i, scaled_pos_i + exp_off});
        end
    endtask

    task automatic t_stamp();
        logic [31:0] s1;
        begin
            xfer(CMD_TIMESTAMP);
            s1 = i_scan.rx[63:32];
            repeat (400) @(negedge clk_i);
            xfer(CMD_TIMESTAMP);
            s1 = i_scan.rx[63:32] - s1;
            chk(s1 >= 32'd19 && s1 <= 32'd22, 1'b1);
        end
    endtask

    task automatic t_save(input logic [31:0] range);
        int f0, r0, n;
        begin
            total_range_i = range;
            f0 = n_flash;
            r0 = n_fram;
            i_scan.save();
            chk_late();
            chk(i_scan.rx[63:32], velocity_i);
            n = 0;
            while (n_flash == f0 && n_fram == r0 && n < 12)
            begin
                @(negedge clk_i);
                n++;
            end
            chk(n < 12, 1'b1);
            if (n >= 12)
                end_of_test();
            nv_ack_i = 1'b1;
            @(negedge clk_i);
            nv_ack_i = 1'b0;
            i_scan.send(CMD_SAVE_EXEC, 32'h0);
            chk_late();
            repeat (6) @(negedge clk_i);
            chk(n_flash - f0, (range == 0));
            chk(n_fram - r0, (range != 0));
            chk(nv_offset_o, exp_off);
            xfer(CMD_OFFSET);
            chk(i_scan.rx[63:32], exp_off);
        end
    endtask

    // mid-run reset drops the preset offset
    task automatic t_reset();
        begin
            @(negedge clk_i);
            arst_n_i = 1'b0;
            repeat (2) @(negedge clk_i);
            arst_n_i = 1'b1;
            exp_off  = ZERO_WORD;
            chk(in_bytes_o, 64'h0);
            chk(offset_o, ZERO_WORD);
            xfer(CMD_OFFSET);
            chk(i_scan.rx[63:32], ZERO_WORD);
        end
    endtask

    initial
    begin
        arst_n_i      = 1'b0;
        nv_ack_i      = 1'b0;
        exp_off       = 32'h0;
        scaled_pos_i  = 32'h0001_2340;
        raw_pos_i     = 32'h0000_abcd;
        velocity_i    = 32'hffff_fff6;
        units_span_i  = 32'h0000_1000;
        total_range_i = 32'h0000_0000;
        repeat (6) @(negedge clk_i);
        arst_n_i = 1'b1;
        chk(in_bytes_o, 64'h0);
        t_select();
        t_preset();
        t_stamp();
        t_save(32'h0);
        t_save(32'h0001_0000);
        chk(wear_err_o, 1'b0);
        t_reset();
        end_of_test();
    end

    initial
    begin
        #1000000;
        n_fail++;
        end_of_test();
    end
endmodule
